//--- ucc_pkg.sv
// shared constants, field positions and carrier types for the upconverter control word
package ucc_pkg;

   // serial frame geometry
   localparam int WORD_W        = 32;
   localparam int INSTR_W       = 8;
   localparam int ADDR_W        = 5;
   localparam int INSTR_RW_BIT  = 7;
   localparam int CNT_W         = 6;

   // address of core_control_word_one on the serial port
   localparam logic [ADDR_W-1:0] CTRL1_ADDR = 5'h00;

   // field positions inside core_control_word_one
   localparam int MODE_HI_BIT      = 25;
   localparam int MODE_LO_BIT      = 24;
   localparam int SINE_SEL_BIT     = 16;
   localparam int ACC_AUTOCLR_BIT  = 13;
   localparam int ACC_CLR_BIT      = 11;
   localparam int RAMP_RELOAD_BIT  = 10;
   localparam int KEY_EN_BIT       = 9;
   localparam int KEY_AUTO_BIT     = 8;
   localparam int CORE_PD_BIT      = 7;
   localparam int CONV_PD_BIT      = 6;
   localparam int REFERENCE_CLOCK_INPUT_PD_BIT    = 5;
   localparam int AUX_PD_BIT       = 4;
   localparam int SLEEP_FAST_BIT   = 3;
   localparam int AUTO_PD_BIT      = 2;
   localparam int IN_ONLY_BIT      = 1;
   localparam int LSB_FIRST_BIT    = 0;

   // implemented bits, reset value and immediate bits
   localparam logic [WORD_W-1:0] CTRL1_MASK  = 32'h0301_2FFF;
   localparam logic [WORD_W-1:0] CTRL1_RESET = 32'h0000_0000;
   localparam logic [WORD_W-1:0] CTRL1_IMMED = 32'h0000_00A0;

   // operating mode encodings
   localparam logic [1:0] MODE_QUAD = 2'h0;
   localparam logic [1:0] MODE_TONE = 2'h1;

   // serial frame phases
   typedef enum logic [1:0] {SP_INSTR, SP_DATA, SP_DONE} ucc_sp_state_t;

   // automatic power-down states
   typedef enum logic [1:0] {APD_RUN, APD_FLUSH, APD_STOP} ucc_apd_state_t;

   // synthesizer-side controls
   typedef struct packed {
      logic       sine_sel;
      logic       acc_hold;
      logic       acc_sync_clr;
      logic       ramp_reload;
      logic       keying_en;
      logic       keying_auto;
   } ucc_dds_ctl_t;

   // power controls
   typedef struct packed {
      logic       core_clk_stop;
      logic       conv_pd;
      logic       reference_clock_input_pd;
      logic       aux_conv_pd;
      logic       full_pd;
      logic       fast_pd;
      logic       chain_flush;
   } ucc_pwr_ctl_t;

   // operating mode decode
   typedef struct packed {
      logic       quad;
      logic       tone;
      logic       interp;
   } ucc_mode_t;

endpackage : ucc_pkg

//--- ucc_sync2.sv
// two-flop synchroniser for a group of pin inputs
`timescale 1ns/10ps
module ucc_sync2
   import ucc_pkg::*;
#(
   parameter int           W    = 1,
   parameter logic [W-1:0] INIT = '0
)
(
   input  wire logic         clk,
   input  wire logic         resetn,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);

   logic [W-1:0] meta_r;

   // first stage feeds only the second
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         meta_r <= INIT;
         q      <= INIT;
      end
      else
      begin
         meta_r <= d;
         q      <= meta_r;
      end
   end

endmodule : ucc_sync2

//--- ucc_autopd.sv
// automatic power-down sequencer driven by the transmit gate
`timescale 1ns/10ps
module ucc_autopd
   import ucc_pkg::*;
#(
   parameter int FLUSH_CYCLES = 16
)
(
   input  wire logic clk,
   input  wire logic resetn,
   input  wire logic enable,
   input  wire logic gate,
   output logic      flush,
   output logic      stop
);

   localparam int FC_W = $clog2(FLUSH_CYCLES + 1);

   ucc_apd_state_t    state_r;
   logic [FC_W-1:0]   cnt_r;

   // run, flush residual data, then hold clocks stopped
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         state_r <= APD_RUN;
         cnt_r   <= '0;
      end
      else if (!enable || gate)
      begin
         state_r <= APD_RUN;
         cnt_r   <= '0;
      end
      else
      begin
         unique case (state_r)
            APD_RUN:
            begin
               state_r <= APD_FLUSH;
               cnt_r   <= '0;
            end
            APD_FLUSH:
            begin
               if (cnt_r == FC_W'(FLUSH_CYCLES - 1))
                  state_r <= APD_STOP;
               cnt_r <= cnt_r + 1'b1;
            end
            APD_STOP:
               state_r <= APD_STOP;
         endcase
      end
   end

   // state-decoded outputs
   assign flush = (state_r == APD_FLUSH);
   assign stop  = (state_r == APD_STOP);

endmodule : ucc_autopd

//--- ucc_ctrl1.sv
// core_control_word_one: serial port, staging and committed copies, control outputs
`timescale 1ns/10ps
module ucc_ctrl1
   import ucc_pkg::*;
#(
   parameter int FLUSH_CYCLES = 16
)
(
   input  wire logic         clk,
   input  wire logic         resetn,
   input  wire logic         sclk,
   input  wire logic         cs_n,
   input  wire logic         sdio_in,
   output logic              sdio_out,
   output logic              sdio_oe_n,
   output logic              sdo,
   input  wire logic         io_update,
   input  wire logic [2:0]   profile,
   input  wire logic         transmit_gate_pin,
   input  wire logic         external_sleep_pin,
   output ucc_dds_ctl_t      dds_ctl,
   output ucc_pwr_ctl_t      pwr_ctl,
   output ucc_mode_t         mode,
   output logic [WORD_W-1:0] ctrl_word
);

   // shift one bit into a word in either order
   function automatic logic [WORD_W-1:0] shift_in(input logic [WORD_W-1:0] w,
                                                   input logic b,
                                                   input logic lsb_first);
      if (lsb_first)
         return {b, w[WORD_W-1:1]};
      else
         return {w[WORD_W-2:0], b};
   endfunction : shift_in

   // bit that leaves a word first in either order
   function automatic logic out_bit(input logic [WORD_W-1:0] w,
                                    input logic lsb_first);
      return lsb_first ? w[0] : w[WORD_W-1];
   endfunction : out_bit

   // word after its leading bit has left
   function automatic logic [WORD_W-1:0] shift_out(input logic [WORD_W-1:0] w,
                                                    input logic lsb_first);
      return lsb_first ? {1'b0, w[WORD_W-1:1]} : {w[WORD_W-2:0], 1'b0};
   endfunction : shift_out

   // instruction addresses this register
   function automatic logic addr_hit(input logic [INSTR_W-1:0] instr);
      return (instr[ADDR_W-1:0] == CTRL1_ADDR);
   endfunction : addr_hit

   // positions of each pin in the synchroniser word
   localparam int PIN_SCLK  = 0;
   localparam int PIN_SDIO  = 1;
   localparam int PIN_UPD   = 2;
   localparam int PIN_CSN   = 3;
   localparam int PIN_GATE  = 4;
   localparam int PIN_SLEEP = 5;
   localparam int PIN_PROF  = 6;

   // synchronised pins; frame select starts high so no frame opens at reset
   localparam int PIN_W = 9;
   localparam logic [PIN_W-1:0] PIN_INIT = 9'h008;

   logic [PIN_W-1:0]  pins_s;
   logic              sclk_s;
   logic              cs_n_s;
   logic              sdio_s;
   logic              upd_s;
   logic              gate_s;
   logic              sleep_s;
   logic [2:0]        prof_s;

   // frame state
   logic              sclk_d_r;
   logic              upd_d_r;
   logic [2:0]        prof_d_r;
   ucc_sp_state_t     sp_state_r;
   logic [CNT_W-1:0]  bit_cnt_r;
   logic [WORD_W-1:0] shift_r;
   logic [WORD_W-1:0] shift_nxt;
   logic [INSTR_W-1:0] instr_nxt;
   logic              rd_r;
   logic              hit_r;
   logic [WORD_W-1:0] tx_r;
   logic              tx_bit_r;
   logic              wr_pulse_r;
   logic [WORD_W-1:0] wdata_r;

   // register copies
   logic [WORD_W-1:0] stage_r;
   logic [WORD_W-1:0] active_r;
   logic [WORD_W-1:0] active_nxt;

   // decoded events
   logic              sclk_rise;
   logic              sclk_fall;
   logic              upd_rise;
   logic              prof_chg;
   logic              lsb_first;
   logic              in_only;
   logic              instr_last;
   logic              data_last;

   // control outputs
   logic              acc_sync_clr_r;
   logic              ramp_reload_r;
   logic              apd_enable;
   logic              apd_flush;
   logic              apd_stop;

   // pins cross into the clock domain
   ucc_sync2 #(
      .W    (PIN_W),
      .INIT (PIN_INIT)
   ) u_sync (
      .clk    (clk),
      .resetn (resetn),
      .d      ({profile, external_sleep_pin, transmit_gate_pin, cs_n, io_update, sdio_in, sclk}),
      .q      (pins_s)
   );

   // unpack synchronised pins
   assign sclk_s  = pins_s[PIN_SCLK];
   assign sdio_s  = pins_s[PIN_SDIO];
   assign upd_s   = pins_s[PIN_UPD];
   assign cs_n_s  = pins_s[PIN_CSN];
   assign gate_s  = pins_s[PIN_GATE];
   assign sleep_s = pins_s[PIN_SLEEP];
   assign prof_s  = pins_s[PIN_PROF +: 3];

   // edge history of synchronised pins
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         sclk_d_r <= 1'b0;
         upd_d_r  <= 1'b0;
         prof_d_r <= 3'h0;
      end
      else
      begin
         sclk_d_r <= sclk_s;
         upd_d_r  <= upd_s;
         prof_d_r <= prof_s;
      end
   end

   // edge and change detection
   assign sclk_rise = sclk_s & ~sclk_d_r;
   assign sclk_fall = ~sclk_s & sclk_d_r;
   assign upd_rise  = upd_s & ~upd_d_r;
   assign prof_chg  = (prof_s != prof_d_r);

   // port format bits follow the committed copy
   assign lsb_first = active_r[LSB_FIRST_BIT];
   assign in_only   = active_r[IN_ONLY_BIT];

   // next shift value and instruction view
   assign shift_nxt  = shift_in(shift_r, sdio_s, lsb_first);
   assign instr_nxt  = lsb_first ? shift_nxt[WORD_W-1:WORD_W-INSTR_W] : shift_nxt[INSTR_W-1:0];
   assign instr_last = (sp_state_r == SP_INSTR) && (bit_cnt_r == CNT_W'(INSTR_W - 1));
   assign data_last  = (sp_state_r == SP_DATA) && (bit_cnt_r == CNT_W'(WORD_W - 1));

   // frame sequencing: instruction byte then one word
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         sp_state_r <= SP_INSTR;
         bit_cnt_r  <= '0;
         shift_r    <= '0;
         rd_r       <= 1'b0;
         hit_r      <= 1'b0;
      end
      else if (cs_n_s)
      begin
         sp_state_r <= SP_INSTR;
         bit_cnt_r  <= '0;
         shift_r    <= '0;
         rd_r       <= 1'b0;
         hit_r      <= 1'b0;
      end
      else if (sclk_rise && sp_state_r != SP_DONE)
      begin
         if (instr_last)
         begin
            sp_state_r <= SP_DATA;
            bit_cnt_r  <= '0;
            shift_r    <= '0;
            rd_r       <= instr_nxt[INSTR_RW_BIT];
            hit_r      <= addr_hit(instr_nxt);
         end
         else if (data_last)
         begin
            sp_state_r <= SP_DONE;
            bit_cnt_r  <= '0;
            shift_r    <= shift_nxt;
         end
         else
         begin
            bit_cnt_r <= bit_cnt_r + 1'b1;
            shift_r   <= shift_nxt;
         end
      end
   end

   // write strobe at end of a matching write frame
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         wr_pulse_r <= 1'b0;
         wdata_r    <= '0;
      end
      else
      begin
         wr_pulse_r <= sclk_rise && !cs_n_s && data_last && !rd_r && hit_r;
         wdata_r    <= shift_nxt & CTRL1_MASK;
      end
   end

   // read data: loaded after the instruction, shifted out on falling edges
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         tx_r     <= '0;
         tx_bit_r <= 1'b0;
      end
      else if (sclk_rise && !cs_n_s && instr_last)
      begin
         tx_r <= addr_hit(instr_nxt) ? (active_r & CTRL1_MASK) : '0;
      end
      else if (sclk_fall && !cs_n_s && rd_r && sp_state_r == SP_DATA)
      begin
         tx_bit_r <= out_bit(tx_r, lsb_first);
         tx_r     <= shift_out(tx_r, lsb_first);
      end
   end

   // data pin turns around only in two-wire reads; three-wire reads use sdo
   assign sdio_out  = tx_bit_r;
   assign sdio_oe_n = ~(!cs_n_s && rd_r && sp_state_r == SP_DATA && !in_only);
   assign sdo       = tx_bit_r;

   // staging copy takes every write
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
         stage_r <= CTRL1_RESET;
      else if (wr_pulse_r)
         stage_r <= wdata_r;
   end

   // committed copy: strobe commits stage, immediate bits follow writes at once
   always_comb
   begin
      active_nxt = active_r;
      if (upd_rise)
         active_nxt = stage_r;
      if (wr_pulse_r)
         active_nxt = (active_nxt & ~CTRL1_IMMED) | (wdata_r & CTRL1_IMMED);
   end

   // committed copy register
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
         active_r <= CTRL1_RESET;
      else
         active_r <= active_nxt;
   end

   // operating mode decode
   assign mode.quad   = (active_r[MODE_HI_BIT:MODE_LO_BIT] == MODE_QUAD);
   assign mode.tone   = (active_r[MODE_HI_BIT:MODE_LO_BIT] == MODE_TONE);
   assign mode.interp = active_r[MODE_HI_BIT];

   // one-cycle clear and reload pulses on strobe or profile change
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         acc_sync_clr_r <= 1'b0;
         ramp_reload_r  <= 1'b0;
      end
      else
      begin
         acc_sync_clr_r <= active_nxt[ACC_AUTOCLR_BIT] & (upd_rise | prof_chg);
         ramp_reload_r  <= active_nxt[RAMP_RELOAD_BIT] & (upd_rise | prof_chg);
      end
   end

   // synthesizer controls
   assign dds_ctl.sine_sel     = active_r[SINE_SEL_BIT] & mode.tone;
   assign dds_ctl.acc_hold     = active_r[ACC_CLR_BIT];
   assign dds_ctl.acc_sync_clr = acc_sync_clr_r;
   assign dds_ctl.ramp_reload  = ramp_reload_r;
   assign dds_ctl.keying_en    = active_r[KEY_EN_BIT];
   assign dds_ctl.keying_auto  = active_r[KEY_EN_BIT] & active_r[KEY_AUTO_BIT];

   // automatic power-down unless single tone
   assign apd_enable = active_r[AUTO_PD_BIT] & ~mode.tone;

   ucc_autopd #(
      .FLUSH_CYCLES (FLUSH_CYCLES)
   ) u_autopd (
      .clk    (clk),
      .resetn (resetn),
      .enable (apd_enable),
      .gate   (gate_s),
      .flush  (apd_flush),
      .stop   (apd_stop)
   );

   // power controls
   assign pwr_ctl.core_clk_stop = active_r[CORE_PD_BIT] | apd_stop;
   assign pwr_ctl.conv_pd       = active_r[CONV_PD_BIT];
   assign pwr_ctl.reference_clock_input_pd     = active_r[REFERENCE_CLOCK_INPUT_PD_BIT];
   assign pwr_ctl.aux_conv_pd   = active_r[AUX_PD_BIT];
   assign pwr_ctl.full_pd       = sleep_s & ~active_r[SLEEP_FAST_BIT];
   assign pwr_ctl.fast_pd       = sleep_s & active_r[SLEEP_FAST_BIT];
   assign pwr_ctl.chain_flush   = apd_flush;

   // committed word for observation
   assign ctrl_word = active_r;

endmodule : ucc_ctrl1

//--- ucc_ctrl1_sva.sv
// concurrent checks on the control word outputs
`timescale 1ns/10ps
module ucc_ctrl1_sva
   import ucc_pkg::*;
#(
   parameter int FLUSH_CYCLES = 16
)
(
   input  wire logic         clk,
   input  wire logic         resetn,
   input  wire logic         sdio_oe_n,
   input  ucc_dds_ctl_t      dds_ctl,
   input  ucc_pwr_ctl_t      pwr_ctl,
   input  ucc_mode_t         mode,
   input  wire logic [WORD_W-1:0] ctrl_word
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);

   // consecutive flush cycles seen so far
   logic [7:0] flush_cnt_r;
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
         flush_cnt_r <= 8'h00;
      else if (pwr_ctl.chain_flush)
         flush_cnt_r <= flush_cnt_r + 8'h01;
      else
         flush_cnt_r <= 8'h00;
   end

   // pin direction, pulses and level decodes
   oe_dir_a: assert property (!sdio_oe_n |-> !ctrl_word[IN_ONLY_BIT]) else $error("sdio driven in input-only mode");
   acc_clr_a: assert property (dds_ctl.acc_sync_clr |-> ctrl_word[ACC_AUTOCLR_BIT]) else $error("stray acc clear");
   ramp_reload_a: assert property (dds_ctl.ramp_reload |-> ctrl_word[RAMP_RELOAD_BIT]) else $error("stray reload");
   keying_ctl_a: assert property (dds_ctl.keying_en == ctrl_word[KEY_EN_BIT] && dds_ctl.keying_auto ==
      (ctrl_word[KEY_AUTO_BIT] && ctrl_word[KEY_EN_BIT])) else $error("keying decode wrong");
   acc_hold_a: assert property (dds_ctl.acc_hold == ctrl_word[ACC_CLR_BIT]) else $error("acc hold wrong");
   sine_sel_a: assert property (dds_ctl.sine_sel == (ctrl_word[SINE_SEL_BIT] && mode.tone))
      else $error("sine select wrong");
   mode_decode_a: assert property (mode == {ctrl_word[25:24] == MODE_QUAD, ctrl_word[25:24] == MODE_TONE,
      ctrl_word[MODE_HI_BIT]}) else $error("mode decode wrong");
   power_bits_a: assert property ({pwr_ctl.conv_pd, pwr_ctl.reference_clock_input_pd, pwr_ctl.aux_conv_pd} == ctrl_word[6:4])
      else $error("power bits wrong");
   core_stop_a: assert property (ctrl_word[CORE_PD_BIT] |-> pwr_ctl.core_clk_stop) else $error("core not stopped");
   sleep_sel_a: assert property ((pwr_ctl.full_pd |-> !ctrl_word[SLEEP_FAST_BIT]) and
      (pwr_ctl.fast_pd |-> ctrl_word[SLEEP_FAST_BIT])) else $error("sleep kind wrong");
   // automatic power-down sequence
   flush_len_a: assert property (pwr_ctl.chain_flush |-> flush_cnt_r < FLUSH_CYCLES) else $error("flush too long");
   flush_stop_a: assert property ($rose(pwr_ctl.core_clk_stop) && !ctrl_word[CORE_PD_BIT] |->
      $past(flush_cnt_r) == FLUSH_CYCLES - 1) else $error("stop without full flush");
   tone_noflush_a: assert property (mode.tone && $past(mode.tone, 2) |-> !pwr_ctl.chain_flush)
      else $error("flush in tone mode");
endmodule : ucc_ctrl1_sva

bind ucc_ctrl1 ucc_ctrl1_sva #(.FLUSH_CYCLES(FLUSH_CYCLES)) ucc_ctrl1_sva_inst (.clk(clk), .resetn(resetn),
   .sdio_oe_n(sdio_oe_n), .dds_ctl(dds_ctl), .pwr_ctl(pwr_ctl), .mode(mode), .ctrl_word(ctrl_word));

//--- ucc_host_model.sv
// host processor model driving the serial programming port
`timescale 1ns/10ps
module ucc_host_model
   import ucc_pkg::*;
(
   input  wire logic clk,
   input  wire logic sdio_out,
   input  wire logic sdio_oe_n,
   input  wire logic sdo,
   output logic      sclk,
   output logic      cs_n,
   output logic      sdio_wire
);
   logic lsb_first  = 1'b0; // host copy of committed bit order
   logic three_wire = 1'b0; // host copy of committed pin mode
   logic host_bit   = 1'b0;

   // shared data pin: device wins while enabled
   assign sdio_wire = !sdio_oe_n ? sdio_out : host_bit;

   // one 40-bit frame; sclk idles low between frames
   task automatic xfer(input logic rd, input logic [ADDR_W-1:0] addr, input logic [WORD_W-1:0] wdata,
                       output logic [WORD_W-1:0] rdata);
      logic [INSTR_W+WORD_W-1:0] frame;
      int j;
      frame = {rd, 2'h0, addr, wdata};
      rdata = '0;
      @(negedge clk);
      cs_n = 1'b0;
      for (int i = 0; i < 40; i++)
      begin
         j = lsb_first ? ((i < 8) ? 32 + i : i - 8) : 39 - i;
         sclk = 1'b0;
         host_bit = (rd && i >= 8) ? ~host_bit : frame[j]; // released pin toggles
         repeat (6) @(negedge clk);
         if (rd && i >= 8)
            rdata[j] = three_wire ? sdo : sdio_wire;
         sclk = 1'b1;
         repeat (4) @(negedge clk);
      end
      sclk = 1'b0;
      repeat (4) @(negedge clk);
      cs_n = 1'b1;
      host_bit = ~host_bit;
      repeat (6) @(negedge clk);
   endtask : xfer

   initial
   begin
      sclk = 1'b0;
      cs_n = 1'b1;
   end
endmodule : ucc_host_model

//--- ucc_ctrl1_bench.sv
// self-checking bench for core_control_word_one
`timescale 1ns/10ps
module ucc_ctrl1_bench;
   import ucc_pkg::*;
   localparam int FLUSH_N = 3;
   // rows: written word beside committed word
   localparam logic [63:0] ROWS [5] = '{{32'hFFFF_FFFC, 32'h0301_2FFC}, {32'h0101_2A00, 32'h0101_2A00},
      {32'hF0F1_D100, 32'h0001_0100}, {32'h0200_0078, 32'h0200_0078}, {32'h0000_0000, 32'h0000_0000}};
   logic clk, resetn, sclk, cs_n, sdio_wire, sdio_out, sdio_oe_n, sdo, io_update, tx_gate, sleep_pin;
   logic [2:0]        profile;
   ucc_dds_ctl_t      dds_ctl;
   ucc_pwr_ctl_t      pwr_ctl;
   ucc_mode_t         mode;
   logic [WORD_W-1:0] ctrl_word, rd, exp_prev;
   int                num_errors = 0;
   int                n_checks = 0;

   ucc_ctrl1 #(.FLUSH_CYCLES(FLUSH_N)) ucc_ctrl1_inst (.clk(clk), .resetn(resetn), .sclk(sclk), .cs_n(cs_n),
      .sdio_in(sdio_wire), .sdio_out(sdio_out), .sdio_oe_n(sdio_oe_n), .sdo(sdo), .io_update(io_update),
      .profile(profile), .transmit_gate_pin(tx_gate), .external_sleep_pin(sleep_pin), .dds_ctl(dds_ctl),
      .pwr_ctl(pwr_ctl), .mode(mode), .ctrl_word(ctrl_word));
   ucc_host_model ucc_host_model_inst (.clk(clk), .sdio_out(sdio_out), .sdio_oe_n(sdio_oe_n), .sdo(sdo),
      .sclk(sclk), .cs_n(cs_n), .sdio_wire(sdio_wire));

   // clock
   initial
   begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   task automatic check_word(input logic [WORD_W-1:0] got, input logic [WORD_W-1:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         num_errors++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check_word

   task automatic check_flag(input logic got, input logic exp);
      n_checks++;
      if (got !== exp)
      begin
         num_errors++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check_flag

   task automatic stop_test();
      $display("checks %0d errors %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : stop_test

   // expected {dds_ctl, pwr_ctl, mode} for a committed word, gate high, sleep low
   function automatic logic [WORD_W-1:0] expect_ctl(input logic [WORD_W-1:0] w);
      logic tone;
      tone = (w[25:24] == MODE_TONE);
      return {16'h0000, w[16] & tone, w[11], 2'h0, w[9], w[8] & w[9], w[7:4], 3'h0,
              w[25:24] == MODE_QUAD, tone, w[25]};
   endfunction : expect_ctl

   task automatic wr(input logic [ADDR_W-1:0] a, input logic [WORD_W-1:0] d);
      ucc_host_model_inst.xfer(1'b0, a, d, rd);
   endtask : wr

   task automatic commit();
      io_update = 1'b1;
      repeat (4) @(negedge clk);
      io_update = 1'b0;
      repeat (8) @(negedge clk);
   endtask : commit

   // update strobe or profile change, then count synthesizer pulses
   task automatic pulse_test(input logic by_update, input int e_acc, input int e_ramp);
      int n_acc;
      int n_ramp;
      n_acc = 0;
      n_ramp = 0;
      if (by_update)
         io_update = 1'b1;
      else
         profile = profile + 3'h1;
      repeat (12)
      begin
         @(negedge clk);
         n_acc += dds_ctl.acc_sync_clr;
         n_ramp += dds_ctl.ramp_reload;
      end
      io_update = 1'b0;
      repeat (4) @(negedge clk);
      check_word(n_acc, e_acc);
      check_word(n_ramp, e_ramp);
   endtask : pulse_test

   // gate low then high with auto power-down committed
   task automatic apd_test(input logic [WORD_W-1:0] w, input int e_flush, input logic e_stop);
      int n_fl;
      n_fl = 0;
      wr(CTRL1_ADDR, w);
      commit();
      tx_gate = 1'b0;
      repeat (20)
      begin
         @(negedge clk);
         n_fl += pwr_ctl.chain_flush;
      end
      check_word(n_fl, e_flush);
      check_flag(pwr_ctl.core_clk_stop, e_stop);
      tx_gate = 1'b1;
      repeat (6) @(negedge clk);
      check_flag(pwr_ctl.core_clk_stop, 1'b0);
   endtask : apd_test

   // watchdog
   initial
   begin
      repeat (40000) @(posedge clk);
      num_errors++;
      $display("watchdog expired at %0t", $time);
      stop_test();
   end

   initial
   begin
      resetn = 1'b0;
      io_update = 1'b0;
      profile = 3'h0;
      tx_gate = 1'b1;
      sleep_pin = 1'b0;
      exp_prev = CTRL1_RESET;
      repeat (3) @(negedge clk);
      check_word(ctrl_word, CTRL1_RESET);
      check_word({16'h0000, dds_ctl, pwr_ctl, mode}, expect_ctl(CTRL1_RESET));
      check_flag(sdio_oe_n, 1'b1);
      resetn = 1'b1;
      repeat (6) @(negedge clk);
      $display("reset test done");
      for (int r = 0; r < 5; r++)
      begin
         wr(CTRL1_ADDR, ROWS[r][63:32]);
         check_word(ctrl_word, (exp_prev & ~CTRL1_IMMED) | (ROWS[r][31:0] & CTRL1_IMMED));
         commit();
         check_word(ctrl_word, ROWS[r][31:0]);
         check_word({16'h0000, dds_ctl, pwr_ctl, mode}, expect_ctl(ROWS[r][31:0]));
         ucc_host_model_inst.xfer(1'b1, CTRL1_ADDR, 32'h0000_0000, rd);
         check_word(rd, ROWS[r][31:0]);
         exp_prev = ROWS[r][31:0];
         $display("row %0d done", r);
      end
      wr(CTRL1_ADDR, 32'h0000_2400);
      pulse_test(1'b1, 1, 1);
      pulse_test(1'b0, 1, 1);
      wr(CTRL1_ADDR, 32'h0000_2000);
      pulse_test(1'b1, 1, 0);
      wr(CTRL1_ADDR, 32'h0000_0000);
      pulse_test(1'b1, 0, 0);
      pulse_test(1'b0, 0, 0);
      $display("pulse test done");
      apd_test(32'h0000_0004, FLUSH_N, 1'b1);
      apd_test(32'h0100_0004, 0, 1'b0);
      $display("auto power-down test done");
      for (int s = 0; s < 2; s++)
      begin
         wr(CTRL1_ADDR, s ? 32'h0000_0008 : 32'h0000_0000);
         commit();
         sleep_pin = 1'b1;
         repeat (4) @(negedge clk);
         check_flag(pwr_ctl.full_pd, s == 0);
         check_flag(pwr_ctl.fast_pd, s == 1);
         sleep_pin = 1'b0;
      end
      $display("sleep test done");
      wr(5'h1F, 32'hFFFF_FFFF);
      commit();
      check_word(ctrl_word, 32'h0000_0008);
      ucc_host_model_inst.xfer(1'b1, 5'h1F, 32'h0000_0000, rd);
      check_word(rd, 32'h0000_0000);
      $display("unmapped test done");
      wr(CTRL1_ADDR, 32'h0000_0003);
      commit();
      ucc_host_model_inst.lsb_first = 1'b1;
      ucc_host_model_inst.three_wire = 1'b1;
      ucc_host_model_inst.xfer(1'b1, CTRL1_ADDR, 32'h0000_0000, rd);
      check_word(rd, 32'h0000_0003);
      wr(CTRL1_ADDR, 32'h0100_2A01);
      commit();
      ucc_host_model_inst.three_wire = 1'b0;
      ucc_host_model_inst.xfer(1'b1, CTRL1_ADDR, 32'h0000_0000, rd);
      check_word(rd, 32'h0100_2A01);
      wr(CTRL1_ADDR, 32'h0000_0000);
      commit();
      ucc_host_model_inst.lsb_first = 1'b0;
      ucc_host_model_inst.xfer(1'b1, CTRL1_ADDR, 32'h0000_0000, rd);
      check_word(rd, 32'h0000_0000);
      $display("bit order test done");
      stop_test();
   end
endmodule : ucc_ctrl1_bench
